// *** rtl/dmx_defines.vh ***
// Register map, field positions, reset values and timing for the DMX receiver
`ifndef DMX_DEFINES_VH
`define DMX_DEFINES_VH

`define CLK_MHZ        250
`define CLK_NS         4
`define BIT_NS         4000
`define BIT_CYC        (`BIT_NS / `CLK_NS)
`define BREAK_US       88
`define BREAK_CYC      (`BREAK_US * `CLK_MHZ)
`define MAB_US         8
`define MAB_CYC        (`MAB_US * `CLK_MHZ)
`define MAB_SHORT_US   4
`define MAB_SHORT_CYC  (`MAB_SHORT_US * `CLK_MHZ)
`define HOLD_MS        1000
`define HOLD_CYC       (`HOLD_MS * 1000 * `CLK_MHZ)
`define FLASH_MS       125
`define FLASH_CYC      (`FLASH_MS * 1000 * `CLK_MHZ)

`define MAX_SLOTS      10'd512
`define NUM_CHAN       12
`define LAST_CHAN      10'd11
`define BAD_RUN        3'd4

`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_SLOTS      8'h08
`define REG_LEVEL0     8'h40

`define CTRL_LATCH     0
`define CTRL_SCENE     1
`define CTRL_SHORTMAB  2
`define CTRL_RESET     3'h0

`define ST_GREEN       0
`define ST_RED         1
`define ST_DMXGOOD     2
`define ST_GREENSOLID  3
`define ST_REDSOLID    4
`define ST_NULLPKT     5
`define ST_ADDRZERO    6

`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// *** rtl/dmx_slot_receiver.v ***
// Serial slot receiver with break and mark-after-break detection
`include "dmx_defines.vh"

module dmx_slot_receiver #(
  parameter [31:0] BREAK_CYC = `BREAK_CYC
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       rxLine,
  input  wire       allowShortMab,
  output reg        slotValid,
  output reg  [7:0] slotData,
  output reg        slotFirst,
  output reg        frameErr,
  output reg        mabErr,
  output reg        breakDet
);
  localparam ST_IDLE = 2'd0;
  localparam ST_BITS = 2'd1;
  localparam ST_LOW  = 2'd2;
  localparam [31:0] BIT_LAST  = `BIT_CYC - 1;
  localparam [31:0] BIT_MID   = `BIT_CYC / 2 - 1;
  localparam [31:0] BRK_LAST  = BREAK_CYC - 1;
  localparam [31:0] MAB_LONG  = `MAB_CYC;
  localparam [31:0] MAB_SHORT = `MAB_SHORT_CYC;

  reg  [1:0]  state_reg;
  reg  [9:0]  tick_reg;
  reg  [3:0]  bitIdx_reg;
  reg  [7:0]  shift_reg;
  reg         rxPrev_reg;
  reg  [15:0] lowCnt_reg;
  reg  [15:0] highCnt_reg;
  reg         afterBreak_reg;
  reg         mabOk_reg;
  reg         errPend_reg;
  wire [15:0] mabMin;

  assign mabMin = allowShortMab ? MAB_SHORT[15:0] : MAB_LONG[15:0];

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= ST_IDLE;
      tick_reg       <= 10'h000;
      bitIdx_reg     <= 4'h0;
      shift_reg      <= 8'h00;
      rxPrev_reg     <= 1'b1;
      lowCnt_reg     <= 16'h0000;
      highCnt_reg    <= 16'h0000;
      afterBreak_reg <= 1'b0;
      mabOk_reg      <= 1'b0;
      errPend_reg    <= 1'b0;
      slotValid      <= 1'b0;
      slotData       <= 8'h00;
      slotFirst      <= 1'b0;
      frameErr       <= 1'b0;
      mabErr         <= 1'b0;
      breakDet       <= 1'b0;
    end else begin
      rxPrev_reg <= rxLine;
      slotValid  <= 1'b0;
      slotFirst  <= 1'b0;
      frameErr   <= 1'b0;
      mabErr     <= 1'b0;
      breakDet   <= 1'b0;
      if (rxLine)
        lowCnt_reg <= 16'h0000;
      else if (lowCnt_reg != 16'hffff)
        lowCnt_reg <= lowCnt_reg + 16'h0001;
      if (!rxLine)
        highCnt_reg <= 16'h0000;
      else if (highCnt_reg != 16'hffff)
        highCnt_reg <= highCnt_reg + 16'h0001;
      if (!rxLine && lowCnt_reg == BRK_LAST[15:0]) begin
        breakDet       <= 1'b1; // RL12
        afterBreak_reg <= 1'b1; // RL13
        mabOk_reg      <= 1'b0;
        errPend_reg    <= 1'b0;
        state_reg      <= ST_LOW; // RL22
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (rxPrev_reg && !rxLine) begin
              state_reg  <= ST_BITS;
              tick_reg   <= 10'h000;
              bitIdx_reg <= 4'h0;
              mabOk_reg  <= highCnt_reg >= mabMin; // RL15
            end
          end
          ST_BITS: begin
            if (tick_reg == BIT_LAST[9:0])
              tick_reg <= 10'h000;
            else
              tick_reg <= tick_reg + 10'h001;
            if (tick_reg == BIT_MID[9:0]) begin
              bitIdx_reg <= bitIdx_reg + 4'h1;
              if (bitIdx_reg == 4'h0) begin
                if (rxLine)
                  state_reg <= ST_IDLE;
              end else if (bitIdx_reg < 4'h9) begin
                shift_reg <= {rxLine, shift_reg[7:1]}; // RL20
              end else if (!rxLine) begin
                state_reg   <= ST_LOW;
                errPend_reg <= 1'b1;
              end else if (bitIdx_reg == 4'ha) begin
                state_reg      <= ST_IDLE; // RL22
                slotValid      <= 1'b1;
                slotData       <= shift_reg;
                slotFirst      <= afterBreak_reg & mabOk_reg; // RL16
                mabErr         <= afterBreak_reg & ~mabOk_reg;
                afterBreak_reg <= 1'b0;
              end
            end
          end
          ST_LOW: begin
            if (rxLine) begin
              state_reg   <= ST_IDLE;
              frameErr    <= errPend_reg;
              errPend_reg <= 1'b0;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// *** rtl/dmx_receiver_status_leds.v ***
// DMX level receiver with channel mapping, status LEDs and AXI4-Lite registers
//
// Summary of operation
// [RL1] Green steady when in-range channels are driven
// [RL2] Green flashes when good data misses our range
// [RL3] Red steady while stream stays bad
// [RL4] Red flashes once per bad packet
// [RL5] Red double-flashes when start address is zero
// [RL6] Channel LED brightness follows drive level
// [RL7] Latch or scene keeps channel LEDs lit
// [RL8] Failed phase single-flashes its channel group
// [RL9] Slots map to dimmers in arrival order
// [RL10] Transmitter sends break then zero start code
// [RL11] Slot value 0-255 is linear drive level
// [RL12] Low of 88 us or more is break
// [RL13] Break abandons packet, starts mark-after-break
// [RL14] Transmitter mark-after-break 8 us to 1 s
// [RL15] Accept 8 us mark, optionally 4 us
// [RL16] First good frame after break is start code
// [RL17] Nonzero start code packets carry no levels
// [RL18] Up to 512 level slots per packet
// [RL19] Short packets update only received slots
// [RL20] Frame: start, 8 data LSB first, 2 stops
// [RL21] Hold last levels at least one second
// [RL22] Survive repeated breaks, accept zero idle
// [RL23] Start address and next eleven slots are ours
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`include "dmx_defines.vh"

module dmx_receiver_status_leds #(
  parameter [31:0] BREAK_CYC = `BREAK_CYC,
  parameter [31:0] HOLD_CYC  = `HOLD_CYC,
  parameter [31:0] FLASH_CYC = `FLASH_CYC
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        rxLine,
  input  wire [9:0]  startAddr,
  input  wire [11:0] breakerTrip,
  input  wire [2:0]  phaseFail,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  output reg         greenLed,
  output reg         redLed,
  output reg  [11:0] chanLed,
  output reg  [95:0] driveLevel
);
  integer k;

  wire       slotValid;
  wire [7:0] slotData;
  wire       slotFirst;
  wire       frameErr;
  wire       mabErr;
  wire       breakDet;

  reg  [2:0]  ctrl_reg;
  reg  [7:0]  dmxLevel [0:11];
  reg  [7:0]  localLevel [0:11];
  reg  [7:0]  drive_reg [0:11];
  reg         nullPkt_reg;
  reg         pktClean_reg;
  reg         inRangePkt_reg;
  reg  [9:0]  slotIdx_reg;
  reg  [9:0]  lastSlots_reg;
  reg         greenSolid_reg;
  reg  [2:0]  badRun_reg;
  reg  [31:0] hold_reg;
  reg  [31:0] redHold_reg;
  reg  [31:0] flashCnt_reg;
  reg  [2:0]  phase_reg;
  reg  [7:0]  pwm_reg;
  reg  [31:0] rd_next;

  wire [9:0] chanOfs;
  wire       inRange;
  wire       addrZero;
  wire       dmxGood;
  wire       localOn;
  wire       badEvent;
  wire       singleFl;
  wire       doubleFl;
  wire [3:0] wrSel;
  wire [3:0] rdSel;

  // Word index of a level register, 4'hf when not one
  function [3:0] levelSel;
    input [7:0] a;
    reg   [7:0] d;
    begin
      d = a - `REG_LEVEL0;
      if (a >= `REG_LEVEL0 && a[1:0] == 2'b00 && d[7:2] < 6'd12)
        levelSel = d[5:2];
      else
        levelSel = 4'hf;
    end
  endfunction

  dmx_slot_receiver #(
    .BREAK_CYC (BREAK_CYC)
  ) u_rx (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .rxLine        (rxLine),
    .allowShortMab (ctrl_reg[`CTRL_SHORTMAB]),
    .slotValid     (slotValid),
    .slotData      (slotData),
    .slotFirst     (slotFirst),
    .frameErr      (frameErr),
    .mabErr        (mabErr),
    .breakDet      (breakDet)
  );

  assign addrZero = (startAddr == 10'h000);
  assign chanOfs  = slotIdx_reg - startAddr;
  assign inRange  = !addrZero && slotIdx_reg >= startAddr && chanOfs <= `LAST_CHAN; // RL23
  assign dmxGood  = (hold_reg != 32'h0);
  assign localOn  = ctrl_reg[`CTRL_LATCH] | ctrl_reg[`CTRL_SCENE];
  assign badEvent = frameErr | mabErr | (slotValid && nullPkt_reg && slotIdx_reg > `MAX_SLOTS);
  assign singleFl = (phase_reg == 3'h0);
  assign doubleFl = (phase_reg == 3'h0) || (phase_reg == 3'h2);
  assign wrSel    = levelSel(awaddr);
  assign rdSel    = levelSel(araddr);

  // Packet tracking and level capture
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nullPkt_reg    <= 1'b0;
      pktClean_reg   <= 1'b0;
      inRangePkt_reg <= 1'b0;
      slotIdx_reg    <= 10'h000;
      lastSlots_reg  <= 10'h000;
      greenSolid_reg <= 1'b0;
      badRun_reg     <= 3'h0;
      hold_reg       <= 32'h0;
      redHold_reg    <= 32'h0;
      for (k = 0; k < `NUM_CHAN; k = k + 1)
        dmxLevel[k] <= 8'h00;
    end else begin
      if (hold_reg != 32'h0)
        hold_reg <= hold_reg - 32'h1; // RL21
      if (redHold_reg != 32'h0)
        redHold_reg <= redHold_reg - 32'h1;
      if (breakDet) begin
        nullPkt_reg <= 1'b0; // RL13
        if (nullPkt_reg) begin
          lastSlots_reg  <= slotIdx_reg - 10'h001;
          greenSolid_reg <= inRangePkt_reg; // RL2
          if (pktClean_reg)
            badRun_reg <= 3'h0;
        end
      end else if (slotValid && slotFirst) begin
        nullPkt_reg    <= (slotData == 8'h00); // RL17
        pktClean_reg   <= 1'b1;
        inRangePkt_reg <= 1'b0;
        slotIdx_reg    <= 10'h001; // RL9
        if (slotData == 8'h00)
          hold_reg <= HOLD_CYC; // RL21
      end else if (slotValid && nullPkt_reg) begin
        if (slotIdx_reg <= `MAX_SLOTS) begin // RL18
          slotIdx_reg <= slotIdx_reg + 10'h001; // RL9
          if (inRange) begin
            dmxLevel[chanOfs[3:0]] <= slotData; // RL11 RL19
            inRangePkt_reg         <= 1'b1;
            greenSolid_reg         <= 1'b1; // RL1
          end
        end
      end
      if (badEvent) begin
        pktClean_reg <= 1'b0;
        redHold_reg  <= FLASH_CYC; // RL4
        if (badRun_reg != `BAD_RUN)
          badRun_reg <= badRun_reg + 3'h1; // RL3
      end
    end
  end

  // Flash timebase and brightness ramp
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flashCnt_reg <= 32'h0;
      phase_reg    <= 3'h0;
      pwm_reg      <= 8'h00;
    end else begin
      pwm_reg <= pwm_reg + 8'h01;
      if (flashCnt_reg >= FLASH_CYC - 32'h1) begin
        flashCnt_reg <= 32'h0;
        phase_reg    <= phase_reg + 3'h1;
      end else begin
        flashCnt_reg <= flashCnt_reg + 32'h1;
      end
    end
  end

  // Drive levels and indicators
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      greenLed   <= 1'b0;
      redLed     <= 1'b0;
      chanLed    <= 12'h000;
      driveLevel <= 96'h0;
      for (k = 0; k < `NUM_CHAN; k = k + 1)
        drive_reg[k] <= 8'h00;
    end else begin
      if (dmxGood)
        greenLed <= greenSolid_reg | phase_reg[0]; // RL1 RL2
      else
        greenLed <= 1'b0;
      if (addrZero)
        redLed <= doubleFl; // RL5
      else if (badRun_reg == `BAD_RUN)
        redLed <= 1'b1; // RL3
      else
        redLed <= (redHold_reg != 32'h0); // RL4
      for (k = 0; k < `NUM_CHAN; k = k + 1) begin
        if (dmxGood)
          drive_reg[k] <= dmxLevel[k];
        else if (localOn)
          drive_reg[k] <= localLevel[k]; // RL7
        else
          drive_reg[k] <= 8'h00;
        driveLevel[8*k +: 8] <= drive_reg[k];
        if (breakerTrip[k])
          chanLed[k] <= doubleFl;
        else if (phaseFail[k % 3])
          chanLed[k] <= singleFl; // RL8
        else
          chanLed[k] <= (drive_reg[k] == 8'hff) || (drive_reg[k] > pwm_reg); // RL6
      end
    end
  end

  // Register write channel
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
      ctrl_reg <= `CTRL_RESET;
      for (k = 0; k < `NUM_CHAN; k = k + 1)
        localLevel[k] <= 8'h00;
    end else begin
      awready <= 1'b0;
      wready  <= 1'b0;
      if (awvalid && wvalid && !awready && !bvalid) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (awready) begin
        bvalid <= 1'b1;
        bresp  <= `RESP_OKAY;
        if (awaddr == `REG_CTRL) begin
          if (wstrb[0])
            ctrl_reg <= wdata[2:0];
        end else if (wrSel != 4'hf) begin
          if (wstrb[0])
            localLevel[wrSel] <= wdata[7:0];
        end else if (awaddr != `REG_STATUS && awaddr != `REG_SLOTS) begin
          bresp <= `RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data select
  always @* begin
    rd_next = 32'h0;
    if (araddr == `REG_CTRL) begin
      rd_next[2:0] = ctrl_reg;
    end else if (araddr == `REG_STATUS) begin
      rd_next[`ST_GREEN]      = greenLed;
      rd_next[`ST_RED]        = redLed;
      rd_next[`ST_DMXGOOD]    = dmxGood;
      rd_next[`ST_GREENSOLID] = greenSolid_reg;
      rd_next[`ST_REDSOLID]   = (badRun_reg == `BAD_RUN);
      rd_next[`ST_NULLPKT]    = nullPkt_reg;
      rd_next[`ST_ADDRZERO]   = addrZero;
    end else if (araddr == `REG_SLOTS) begin
      rd_next[9:0] = lastSlots_reg;
    end else if (rdSel != 4'hf) begin
      rd_next[7:0] = drive_reg[rdSel];
    end
  end

  // Register read channel
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `RESP_OKAY;
    end else begin
      arready <= 1'b0;
      if (arvalid && !arready && !rvalid)
        arready <= 1'b1;
      if (arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_next;
        if (araddr == `REG_CTRL || araddr == `REG_STATUS || araddr == `REG_SLOTS || rdSel != 4'hf)
          rresp <= `RESP_OKAY;
        else
          rresp <= `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** tb/dmx_rx_props.sv ***
// Port-level checks on the DMX receiver
module dmx_rx_props #(
  parameter [31:0] FLASH_CYC = 32'd16
) (
  input logic        ref_clk,
  input logic        rst,
  input logic        rxLine,
  input logic [9:0]  startAddr,
  input logic [11:0] breakerTrip,
  input logic [2:0]  phaseFail,
  input logic        awvalid,
  input logic        awready,
  input logic        wvalid,
  input logic        wready,
  input logic [1:0]  bresp,
  input logic        bvalid,
  input logic        bready,
  input logic        arvalid,
  input logic        arready,
  input logic [31:0] rdata,
  input logic [1:0]  rresp,
  input logic        rvalid,
  input logic        rready,
  input logic        redLed,
  input logic [11:0] chanLed,
  input logic [95:0] driveLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FlashWin = 8 * FLASH_CYC + 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  aw_pair_a: assert property (awready |-> awvalid && wvalid) else $error("awready without both valids");
  wr_resp_a: assert property (awvalid && awready && wvalid && wready |=> bvalid) else $error("no write response");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  rd_resp_a: assert property (arvalid && arready |=> rvalid) else $error("no read response");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  addr_zero_a: assert property ((startAddr == 10'h000) [*2] |-> ##[0:FlashWin] (redLed || startAddr != 10'h000))
    else $error("red indicator idle with zero address");
  phase_flash_a: assert property ($rose(chanLed[0]) && phaseFail[0] && $past(phaseFail[0], 200) && !breakerTrip[0]
    |-> chanLed[0] [*8]) else $error("phase flash too short");
  level_stop_a: assert property ($changed(driveLevel) |-> $past(rxLine) && $past(rxLine, 3))
    else $error("level changed outside stop bit");
  wr_c: cover property (bvalid && bready);
  rd_err_c: cover property (rvalid && rready && rresp == 2'b10);
  lvl_c: cover property ($changed(driveLevel));
endmodule

// *** tb/dmx_console_model.sv ***
// Console transmitter model driving the DMX line
`include "dmx_defines.vh"
module dmx_console_model (
  input  logic ref_clk,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxLine = 1'b1;
  task automatic hold(input logic lvl, input int cyc);
    rxLine <= lvl;
    repeat (cyc) @(posedge ref_clk);
  endtask
  task automatic sendBreak(input int cyc);
    hold(1'b0, cyc);
  endtask
  task automatic sendMark(input int cyc);
    hold(1'b1, cyc);
  endtask
  // Back-to-back frames leave no idle time
  task automatic sendByte(input logic [7:0] b);
    int i;
    hold(1'b0, `BIT_CYC);
    for (i = 0; i < 8; i++) hold(b[i], `BIT_CYC);
    hold(1'b1, 2 * `BIT_CYC);
  endtask
  // Frame with a low first stop bit; returns as the line goes back to mark
  task automatic sendBadFrame();
    hold(1'b0, `BIT_CYC);
    hold(1'b1, `BIT_CYC);
    hold(1'b0, 17 * `BIT_CYC / 2);
    rxLine <= 1'b1;
  endtask
endmodule

// *** tb/dmx_receiver_status_leds_tb_top.sv ***
// Self-checking bench for the DMX receiver with status LEDs
`include "dmx_defines.vh"
module dmx_receiver_status_leds_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BrkCyc   = 9200;
  localparam int FlashCyc = 16;
  logic        ref_clk, rst, rxLine;
  logic [9:0]  startAddr;
  logic [11:0] breakerTrip, chanLed;
  logic [2:0]  phaseFail;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, greenLed, redLed;
  logic [1:0]  bresp, rresp, rr;
  logic [95:0] driveLevel;
  int          errTotal, testsRun, cnt0, cnt1, cntR;

  dmx_console_model tx (.ref_clk(ref_clk), .rxLine(rxLine));
  dmx_receiver_status_leds #(.BREAK_CYC(BrkCyc), .HOLD_CYC(200000), .FLASH_CYC(FlashCyc)) uut (
    .ref_clk(ref_clk), .rst(rst), .rxLine(rxLine), .startAddr(startAddr), .breakerTrip(breakerTrip),
    .phaseFail(phaseFail), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .greenLed(greenLed), .redLed(redLed), .chanLed(chanLed),
    .driveLevel(driveLevel));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic waitFor(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (s !== 1'b1 && n < 200);
    if (s !== 1'b1) begin
      errTotal++;
      $display("[FAIL] %0t handshake timeout", $time);
      wrapUp();
    end
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    waitFor(awready);
    awvalid <= 1'b0;
    if (wready !== 1'b1) waitFor(wready);
    wvalid <= 1'b0;
    waitFor(bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    waitFor(arready);
    arvalid <= 1'b0;
    waitFor(rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Counts lit cycles of the two first channel LEDs and the red LED
  task automatic countLeds(input int n);
    cnt0 = 0;
    cnt1 = 0;
    cntR = 0;
    repeat (n) begin
      @(posedge ref_clk);
      cnt0 += (chanLed[0] === 1'b1);
      cnt1 += (chanLed[1] === 1'b1);
      cntR += (redLed === 1'b1);
    end
  endtask

  task automatic packet(input logic [7:0] code, input logic [7:0] s1, input logic [7:0] s2, input int num);
    tx.sendBreak(BrkCyc + 100);
    tx.sendMark(`MAB_CYC);
    tx.sendByte(code);
    tx.sendByte(s1);
    if (num > 1) tx.sendByte(s2);
    repeat (8) @(posedge ref_clk);
  endtask

  initial begin
    rst = 1'b1;
    startAddr = 10'h000;
    breakerTrip = 12'h000;
    phaseFail = 3'h0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    countLeds(8 * FlashCyc);
    check(cntR, 2 * FlashCyc);
    axiRd(`REG_STATUS, rd, rr);
    check(rd[`ST_ADDRZERO], 1'b1);
    startAddr <= 10'd1;
    axiWr(`REG_CTRL, 32'h0000_0003, rr);
    check(rr, `RESP_OKAY);
    axiRd(`REG_CTRL, rd, rr);
    check(rd, 32'h0000_0003);
    axiWr(`REG_STATUS, 32'h0000_00ff, rr);
    check(rr, `RESP_OKAY);
    axiWr(8'h80, 32'h0000_0001, rr);
    check(rr, `RESP_SLVERR);
    axiRd(8'h80, rd, rr);
    check(rd, 32'h0000_0000);
    check(rr, `RESP_SLVERR);
    packet(8'h00, 8'ha5, 8'h3c, 2);
    check(driveLevel[15:0], 16'h3ca5);
    check(greenLed, 1'b1);
    axiRd(`REG_LEVEL0 + 8'h04, rd, rr);
    check(rd, 32'h0000_003c);
    countLeds(256);
    check(cnt0, 32'h0000_00a5);
    check(cnt1, 32'h0000_003c);
    phaseFail <= 3'b001;
    breakerTrip <= 12'h002;
    repeat (4) @(posedge ref_clk);
    countLeds(64 * FlashCyc);
    check(cnt0, 8 * FlashCyc);
    check(cnt1, 16 * FlashCyc);
    phaseFail <= 3'h0;
    breakerTrip <= 12'h000;
    packet(8'h07, 8'h11, 8'h00, 1);
    check(driveLevel[7:0], 8'ha5);
    axiRd(`REG_SLOTS, rd, rr);
    check(rd, 32'd2);
    tx.sendBadFrame();
    countLeds(64);
    check(cntR, FlashCyc);
    wrapUp();
  end
endmodule

bind dmx_receiver_status_leds dmx_rx_props #(.FLASH_CYC(FLASH_CYC)) props (
  .ref_clk(ref_clk), .rst(rst), .rxLine(rxLine), .startAddr(startAddr), .breakerTrip(breakerTrip),
  .phaseFail(phaseFail), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .redLed(redLed), .chanLed(chanLed),
  .driveLevel(driveLevel));
